// *** logic/usb_register_command_port.sv ***
// Purpose: device-side usb command port: eight-byte commands in, eight-byte answers out
// Assumes: a usb full-speed serial engine delivers endpoint bytes at one per clock at most
// Notes: register meanings live in the register core beyond cmd/resp ports
// Notes: one command in flight; bulk out bytes are refused until its answer is queued
// Notes: the overrun flag is sticky until reset so a misbehaving host stays visible
// Notes: a deep answer queue lets a slow host lag without stalling the framing logic
`timescale 1ns/1ps
`include "usb_cmd_cfg.svh"
module usb_register_command_port (
	input  wire logic                      clk,
	input  wire logic                      reset,
	// bulk out stream from the serial engine
	input  wire usb_cmd_pkg::ep_byte_type  out_byte,
	input  wire logic                      out_valid,
	output logic                           out_ready,
	// bulk in stream to the serial engine
	output usb_cmd_pkg::ep_byte_type       in_byte,
	output logic                           in_valid,
	input  wire logic                      in_ready,
	// control setup fields, checked for vendor interface requests
	input  wire logic [7:0]                setup_type,
	input  wire logic                      setup_valid,
	output logic                           setup_accept,
	// register core
	output usb_cmd_pkg::command_type       cmd,
	output logic                           cmd_valid,
	input  wire logic                      cmd_done,
	input  wire logic [63:0]               resp_data,
	input  wire logic [3:0]                resp_len,
	// status
	output logic                           overrun_r
);
	usb_cmd_pkg::port_state_type state_r, state_nxt;
	logic [7:0]              shift_r [`CMD_BYTES];
	logic [7:0]              shift_nxt [`CMD_BYTES];
	logic [`CMD_CNT_W-1:0]   cnt_r, cnt_nxt;
	logic [`EP_BUF_AW:0]     xfer_r, xfer_nxt;
	logic                    overrun_nxt;
	logic [7:0]              resp_r [`CMD_BYTES];
	logic [7:0]              resp_nxt [`CMD_BYTES];
	// answer bytes as the core presents them, before latching
	logic [7:0]              resp_pick [`CMD_BYTES];
	genvar                   g;
	logic [`CMD_CNT_W-1:0]   rcnt_r, rcnt_nxt;
	logic                    query_r, query_nxt;
	logic                    take, good_ep;
	logic [8:0]              fifo_in, fifo_out;
	logic                    fifo_in_valid, fifo_in_ready, fifo_out_valid;

	// vendor interface requests in either direction are ours
	always_comb
	begin
		setup_accept = setup_valid
			&& ((setup_type & ~`CTL_DIR_IN) == (`VENDOR_REQUEST_TYPE | `INTERFACE_RECIPIENT_CODE));
	end

	// only bulk out bytes are taken, and only while collecting
	assign good_ep   = (out_byte.ep == `EP_BULK_OUT);
	assign out_ready = (state_r == usb_cmd_pkg::st_collect);
	assign take      = out_valid & out_ready & good_ep;

	// command register drives the core from flops
	always_comb
	begin
		cmd.addr    = shift_r[0];
		cmd.payload = {shift_r[1], shift_r[2], shift_r[3], shift_r[4],
			shift_r[5], shift_r[6], shift_r[7]};
		cmd.query   = query_r;
		cmd_valid   = (state_r == usb_cmd_pkg::st_issue);
	end

	// command assembly, issue and reply sequencing
	always_comb
	begin
		state_nxt   = state_r;
		shift_nxt   = shift_r;
		cnt_nxt     = cnt_r;
		xfer_nxt    = xfer_r;
		overrun_nxt = overrun_r;
		query_nxt   = query_r;
		case (state_r)
			usb_cmd_pkg::st_collect:
			begin
				if (take)
				begin
					shift_nxt[cnt_r] = out_byte.data;
					// a packet over the endpoint buffer is flagged, not trusted
					if (xfer_r == (`EP_BUF_AW+1)'(`EP_BUF_BYTES))
						overrun_nxt = 1'b1;
					else
						xfer_nxt = (`EP_BUF_AW+1)'(xfer_r + 1'b1);
					if (out_byte.last)
						xfer_nxt = '0;
					if (cnt_r == `CMD_LAST_IDX)
					begin
						cnt_nxt   = '0;
						state_nxt = usb_cmd_pkg::st_issue;
						query_nxt = (shift_r[0] >= `REG_QUERY_LO)
							&& (shift_r[0] <= `REG_QUERY_HI);
					end
					else
						cnt_nxt = `CMD_CNT_W'(cnt_r + 1'b1);
				end
			end
			usb_cmd_pkg::st_issue:
				state_nxt = usb_cmd_pkg::st_wait;
			usb_cmd_pkg::st_wait:
			begin
				// the core may take any number of cycles; nothing times out here
				if (cmd_done)
					state_nxt = usb_cmd_pkg::st_reply;
			end
			usb_cmd_pkg::st_reply:
			begin
				// back to collecting once the eighth answer byte is queued
				if (fifo_in_ready && rcnt_r == `CMD_LAST_IDX)
					state_nxt = usb_cmd_pkg::st_collect;
			end
			default:
				state_nxt = usb_cmd_pkg::st_collect;
		endcase
	end

	// framing registers; command bytes reset to pad so cmd never shows unknowns
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_r   <= usb_cmd_pkg::st_collect;
			cnt_r     <= '0;
			xfer_r    <= '0;
			overrun_r <= 1'b0;
			query_r   <= 1'b0;
			for (int i = 0; i < `CMD_BYTES; i++)
				shift_r[i] <= `PAD_BYTE;
		end
		else
		begin
			state_r   <= state_nxt;
			cnt_r     <= cnt_nxt;
			xfer_r    <= xfer_nxt;
			overrun_r <= overrun_nxt;
			query_r   <= query_nxt;
			shift_r   <= shift_nxt;
		end
	end

	// answer bytes right-aligned at the low end; upper positions and config answers pad
	generate
		for (g = 0; g < `CMD_BYTES; g++)
		begin : g_pick
			assign resp_pick[g] = (query_r && (`CMD_BYTES - 1 - g) < int'(resp_len))
				? resp_data[8*(`CMD_BYTES-1-g) +: 8] : `PAD_BYTE;
		end
	endgenerate

	// answer capture on completion, then queueing msb first
	always_comb
	begin
		resp_nxt      = resp_r;
		rcnt_nxt      = rcnt_r;
		fifo_in_valid = 1'b0;
		if (state_r == usb_cmd_pkg::st_wait && cmd_done)
		begin
			// the core's answer is latched in the cycle it reports completion
			resp_nxt = resp_pick;
			rcnt_nxt = '0;
		end
		else if (state_r == usb_cmd_pkg::st_reply)
		begin
			// all eight bytes always go, so the host sees completion
			fifo_in_valid = 1'b1;
			if (fifo_in_ready)
				rcnt_nxt = `CMD_CNT_W'(rcnt_r + 1'b1);
		end
	end

	// answer registers; pad after reset so nothing stale can be queued
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rcnt_r <= '0;
			for (int i = 0; i < `CMD_BYTES; i++)
				resp_r[i] <= `PAD_BYTE;
		end
		else
		begin
			rcnt_r <= rcnt_nxt;
			resp_r <= resp_nxt;
		end
	end

	// response queue toward the bulk in endpoint; last flag marks byte eight
	assign fifo_in = {resp_r[rcnt_r], (rcnt_r == `CMD_LAST_IDX)};

	byte_fifo #(
		.WIDTH (9),
		.DEPTH (`RESP_FIFO_DEPTH),
		.AW    (`RESP_FIFO_AW)
	) u_resp_fifo (
		.clk       (clk),
		.reset     (reset),
		.in_data   (fifo_in),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out),
		.out_valid (fifo_out_valid),
		.out_ready (in_ready)
	);

	// bytes go out on the bulk in endpoint
	always_comb
	begin
		in_byte.ep   = `EP_BULK_IN;
		in_byte.data = fifo_out[8:1];
		in_byte.last = fifo_out[0];
		in_valid     = fifo_out_valid;
	end
endmodule // usb_register_command_port

// *** shared/usb_cmd_cfg.svh ***
// Purpose: constants for the usb register command port
// Assumes: byte-wide endpoint streams from a usb full-speed serial engine
// Notes: header holds definitions only
// Function
// - port works as a usb 2.0 full-speed function at 12 Mbit/s
// - bulk in endpoint is 0x81, bulk out endpoint is 0x02
// - control direction 0x80 in, 0x00 out, vendor type, interface recipient 0x01
// - every endpoint, bulk and control, has a 16-byte buffer
// - each register command is exactly eight bytes long
// - first byte is register address and decides how the rest is read
// - bytes returned after a configuration write carry no meaning
// - valid readback only after a query register write such as 0x20
// - response becomes available as soon as a query write is accepted; the port queues it only after cmd_done from the register core
// - read returns eight bytes, most significant byte first
// - response right-aligned at least significant byte, upper bytes padded
`ifndef USB_CMD_CFG_SVH
`define USB_CMD_CFG_SVH

`define FS_BIT_RATE_MBPS   12
`define EP_BULK_IN         8'h81
`define EP_BULK_OUT        8'h02
`define CTL_DIR_IN         8'h80
`define CTL_DIR_OUT        8'h00
`define VENDOR_REQUEST_TYPE 8'h40
`define INTERFACE_RECIPIENT_CODE 8'h01
`define EP_BUF_BYTES       16
`define EP_BUF_AW          4
`define CMD_BYTES          8
`define CMD_CNT_W          3
`define CMD_LAST_IDX       3'h7
`define REG_QUERY_LO       8'h20
`define REG_QUERY_HI       8'h23
`define REG_TEMPERATURE    8'h22
`define PAD_BYTE           8'h00
`define RESP_FIFO_DEPTH    32
`define RESP_FIFO_AW       5

`endif

// *** shared/usb_cmd_pkg.sv ***
// Purpose: types shared by the command port and its user side
// Assumes: usb_cmd_cfg.svh supplies the numbers
// Notes: byte streams carry the endpoint number beside the data
package usb_cmd_pkg;

	// one byte of a bulk endpoint stream
	typedef struct packed {
		logic [7:0] ep;
		logic [7:0] data;
		logic       last;
	} ep_byte_type;

	// decoded command handed to the register core
	typedef struct packed {
		logic [7:0]  addr;
		logic [55:0] payload;
		logic        query;
	} command_type;

	typedef enum logic [1:0] {
		st_collect,
		st_issue,
		st_wait,
		st_reply
	} port_state_type;

endpackage

// *** logic/byte_fifo.sv ***
// Purpose: parameterised flip-flop fifo with valid and ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: full and empty come from a count, no read-ahead
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32,
	parameter int AW    = 5
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
	logic [AW:0]      cnt_r, cnt_nxt;
	logic             push, pop;

	// honest flags from the occupancy count
	assign in_ready  = (cnt_r != AW'(0) + (AW+1)'(DEPTH)) ;
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem_r[rd_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// pointer and count next values
	always_comb
	begin
		wr_nxt  = push ? AW'(wr_r + 1'b1) : wr_r;
		rd_nxt  = pop ? AW'(rd_r + 1'b1) : rd_r;
		cnt_nxt = cnt_r;
		if (push && !pop)
			cnt_nxt = (AW+1)'(cnt_r + 1'b1);
		else if (pop && !push)
			cnt_nxt = (AW+1)'(cnt_r - 1'b1);
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end
		else
		begin
			wr_r  <= wr_nxt;
			rd_r  <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// storage entries, one per index
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++)
		begin : g_ent
			always_ff @(posedge clk)
			begin
				if (push && wr_r == AW'(g))
					mem_r[g] <= in_data;
			end
		end
	endgenerate
endmodule // byte_fifo

// *** testbench/usb_cmd_port_chk.sv ***
// Purpose: port assertions for the command port
// Assumes: one clock, sync reset
// Notes: a byte counter mirrors command framing
`timescale 1ns/1ps
module usb_cmd_port_chk (
	input wire logic clk,
	input wire logic reset,
	input wire usb_cmd_pkg::ep_byte_type out_byte,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire usb_cmd_pkg::ep_byte_type in_byte,
	input wire logic in_valid,
	input wire logic in_ready,
	input wire logic [7:0] setup_type,
	input wire logic setup_valid,
	input wire logic setup_accept,
	input wire logic cmd_valid,
	input wire logic cmd_done,
	input wire logic overrun_r
);
	logic [2:0] cnt_r;
	logic [2:0] cnt_nxt;
	logic       take;
	// taken bulk out bytes, modulo eight
	assign take = out_valid && out_ready && out_byte.ep == 8'h02;
	always_comb
	begin
		cnt_nxt = take ? cnt_r + 3'h1 : cnt_r;
	end
	always_ff @(posedge clk)
	begin
		cnt_r <= reset ? 3'h0 : cnt_nxt;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_eighth_issues: assert property (take && cnt_r == 3'h7 |=> cmd_valid)
		else $error("no command");
	a_busy_refuses: assert property (cmd_valid |-> !out_ready)
		else $error("taken while busy");
	a_cmd_pulse: assert property (cmd_valid |=> !cmd_valid)
		else $error("long strobe");
	a_reply_prompt: assert property (cmd_done |-> ##[1:3] in_valid)
		else $error("late reply");
	a_in_endpoint: assert property (in_valid |-> in_byte.ep == 8'h81)
		else $error("bad endpoint");
	a_in_hold: assert property (in_valid && !in_ready |=> in_valid && $stable(in_byte))
		else $error("byte moved");
	a_setup_vendor: assert property (setup_valid && setup_type[6:0] == 7'h41 |-> setup_accept)
		else $error("setup refused");
	a_setup_other: assert property (setup_accept |-> setup_valid && setup_type[6:0] == 7'h41)
		else $error("setup taken");
	cover property (cmd_valid);
	cover property (in_valid && in_ready && in_byte.last);
	a_overrun_sticky: assert property (overrun_r |=> overrun_r)
		else $error("overrun lost");
	cover property (setup_accept);
	cover property (overrun_r);
endmodule // usb_cmd_port_chk
bind usb_register_command_port usb_cmd_port_chk chk (.clk, .reset, .out_byte, .out_valid,
	.out_ready, .in_byte, .in_valid, .in_ready, .setup_type, .setup_valid, .setup_accept,
	.cmd_valid, .cmd_done, .overrun_r);

// *** testbench/usb_host_model.sv ***
// Purpose: host model for the bulk endpoints
// Assumes: tasks are entered at a rising edge
// Notes: slow stalls the reader every other cycle
`timescale 1ns/1ps
module usb_host_model (
	input wire logic clk,
	input wire logic slow,
	input wire logic out_ready,
	input wire usb_cmd_pkg::ep_byte_type in_byte,
	input wire logic in_valid,
	output usb_cmd_pkg::ep_byte_type out_byte,
	output logic out_valid,
	output logic in_ready
);
	// idle at time zero
	initial
	begin
		out_byte = '0;
		out_valid = 1'b0;
		in_ready = 1'b0;
	end
	// eight bytes, each held until taken; ok drops if a byte waits out its bound
	task automatic send(input logic [63:0] c, input bit nolast, input bit noise,
		output bit ok);
		int k;
		ok = 1'b1;
		// a byte on a foreign endpoint first; the port must drop it
		if (noise)
		begin
			out_byte <= '{8'h01, 8'h5a, 1'b1};
			out_valid <= 1'b1;
			@(posedge clk);
		end
		for (int i = 0; i < 8; i++)
		begin
			out_byte <= '{8'h02, c[63-8*i -: 8], i == 7 && !nolast};
			out_valid <= 1'b1;
			@(posedge clk);
			for (k = 0; k < 20 && !out_ready; k++)
				@(posedge clk);
			if (!out_ready)
				ok = 1'b0;
		end
		out_valid <= 1'b0;
		out_byte <= ~out_byte; // no stale byte after release
	endtask
	// all eight reply bytes, msb first
	task automatic recv(output logic [63:0] r, output logic [7:0] l);
		int n;
		n = 0;
		r = '0;
		l = '0;
		for (int k = 0; k < 300 && n < 8; k++)
		begin
			in_ready <= k[0] || !slow;
			@(posedge clk);
			if (in_valid && in_ready)
			begin
				r = {r[55:0], in_byte.data};
				l = {l[6:0], in_byte.last};
				n++;
			end
		end
		in_ready <= 1'b0;
	endtask
endmodule // usb_host_model

// *** testbench/test_usb_register_command_port.sv ***
// Purpose: self-checking bench for the command port
// Assumes: register core answered here, host in its model
// Notes: replies right-aligned, zero padded
`timescale 1ns/1ps
module test_usb_register_command_port;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic cmd_done = 1'b0;
	logic setup_valid = 1'b0;
	logic slow = 1'b0;
	logic [7:0] setup_type = 8'h00;
	logic [63:0] resp_data = 64'h8877665544332211;
	logic [3:0] resp_len = 4'h0;
	logic out_valid, out_ready, in_valid, in_ready, setup_accept, cmd_valid, overrun_r;
	usb_cmd_pkg::ep_byte_type out_byte, in_byte;
	usb_cmd_pkg::command_type cmd;
	int mismatches = 0;
	int samples_checked = 0;
	usb_register_command_port uut (.clk, .reset, .out_byte, .out_valid, .out_ready, .in_byte,
		.in_valid, .in_ready, .setup_type, .setup_valid, .setup_accept, .cmd, .cmd_valid,
		.cmd_done, .resp_data, .resp_len, .overrun_r);
	usb_host_model host (.clk, .slow, .out_ready, .in_byte, .in_valid, .out_byte,
		.out_valid, .in_ready);
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	// register core answers three cycles late
	always @(posedge clk)
		if (cmd_valid)
		begin
			repeat (3) @(posedge clk);
			cmd_done <= 1'b1;
			@(posedge clk);
			cmd_done <= 1'b0;
		end
	task automatic check(input string n, input logic [63:0] s, input logic [63:0] e);
		samples_checked++;
		if (s !== e)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// one command and its reply
	task automatic xfer(input logic [63:0] c, input logic [63:0] e, input bit nolast = 1'b0,
		input bit noise = 1'b0);
		logic [63:0] r;
		logic [7:0] l;
		bit ok;
		int k;
		host.send(c, nolast, noise, ok);
		check("sent", 64'(ok), 64'h1);
		for (k = 0; k < 20 && !cmd_valid; k++)
			@(posedge clk);
		if (!cmd_valid)
		begin
			mismatches++;
			print_verdict;
		end
		check("addr", 64'(cmd.addr), 64'(c[63:56]));
		check("payload", 64'(cmd.payload), 64'(c[55:0]));
		check("query", 64'(cmd.query), 64'(c[63:56] inside {[8'h20:8'h23]}));
		host.recv(r, l);
		check("reply", r, e);
		check("last", 64'(l), 64'h1);
	endtask
	// each query address, several valid lengths
	task automatic t_query;
		for (int a = 8'h20; a <= 8'h23; a++)
		begin
			resp_len <= 4'(a - 8'h1b);
			xfer({8'(a), 56'h01020304050607},
				resp_data & ((64'h1 << (8 * (a - 8'h1b))) - 64'h1));
		end
	endtask
	// configuration writes give padding only
	task automatic t_config;
		xfer(64'h1000000000000001, 64'h0);
		xfer(64'h2400000000000000, 64'h0);
	endtask
	// stalling reader, commands back to back
	task automatic t_stall;
		slow <= 1'b1;
		resp_len <= 4'h2;
		xfer(64'h2100000000000000, 64'h2211);
		xfer(64'h1200000000000005, 64'h0);
		slow <= 1'b0;
	endtask
	// two unterminated commands fill the 16-byte buffer; the next bulk out byte overruns
	task automatic t_overrun;
		resp_len <= 4'h1;
		xfer(64'h2000000000000001, 64'h11, 1'b1, 1'b0);
		xfer(64'h1100000000000002, 64'h0, 1'b1, 1'b0);
		check("full", 64'(overrun_r), 64'h0);
		xfer(64'h1300000000000003, 64'h0, 1'b0, 1'b1);
		check("overrun", 64'(overrun_r), 64'h1);
	endtask
	// vendor interface requests only
	task automatic t_setup;
		logic [7:0] t [5] = '{8'hc1, 8'h41, 8'hc0, 8'h40, 8'hc2};
		foreach (t[i])
		begin
			setup_type <= t[i];
			setup_valid <= 1'b1;
			@(posedge clk);
			check("setup", 64'(setup_accept), 64'(t[i][6:0] == 7'h41));
		end
		setup_valid <= 1'b0;
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		check("overrun", 64'(overrun_r), 64'h0);
		t_query;
		t_config;
		t_stall;
		t_overrun;
		// second reset in mid-run clears the sticky flag
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		check("overrun", 64'(overrun_r), 64'h0);
		t_config;
		t_setup;
		print_verdict;
	end
endmodule // test_usb_register_command_port
